// [verilog/clock_gen_status_logic.v]
// Purpose: Status and interrupt-flag logic of a loop-based clock generator, on AHB-Lite.
// Assumes: All generator inputs are synchronous to hclk; one AHB-Lite master.
// Notes:   Each access takes one wait state so read data leave a flip-flop.
//
// Operation
// - Mode status in bits 7:6.
// - Mode status follows select after crossing.
// - Bit 5 shows selected reference.
// - Sticky loss-of-lock flag in bit 4.
// - Bit 3 live lock indicator.
// - Lock reads zero outside engaged modes.
// - Sticky loss-of-clock flag in bit 2.
// - Bit 1 external reference stable.
// - Bit 0 interrupt pending, reset clears.
// - Clear by read then write one.
// - New interrupt restarts the clear sequence.
// - Writing zero to flag keeps it set but cancels an armed clear.
// - Oscillator stable after two good samples.
// - Leaving off to an engaged mode waits for oscillator stable.
// - Self-clocked monitoring starts after stable.
// - Entering off clears oscillator stable.
// - Lock loss gives interrupt or reset.
// - Clock loss gives interrupt or reset.
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`default_nettype none
`include "clock_gen_status_consts.vh"

module clock_gen_status_logic (
  // Clock and reset.
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave port.
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Generator state from the loop and reference machinery.
  input  wire        gen_off,
  input  wire        fll_locked,
  input  wire        lock_lost_pulse,
  input  wire        clock_lost_pulse,
  input  wire        ext_ref_stable_in,
  input  wire        crystal_selected,
  input  wire        osc_sample_valid,
  input  wire        osc_sample_in_tol,
  input  wire        osc_clock_active,
  // Requests to the rest of the chip.
  output reg  [1:0]  mode_request,
  output reg         osc_monitor_enable,
  output reg         reset_request,
  output reg         irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg        pend_reg;            // Data phase in progress.
  reg        pend_write_reg;
  reg [11:0] pend_addr_reg;
  reg [3:0]  control_reg;
  reg [1:0]  mode_status_reg;
  reg [1:0]  mode_status_next;
  reg        leave_wait_reg;
  reg        lol_flag_reg;
  reg        loc_flag_reg;
  reg        irq_flag_reg;
  reg        irq_flag_next;
  reg        clear_armed_reg;
  reg        clear_armed_next;
  reg        osc_stable_reg;
  reg [1:0]  good_count_reg;
  reg [`EV_WIDTH-1:0] ev_status_reg;
  reg [`EV_WIDTH-1:0] ev_enable_reg;
  reg [`EV_WIDTH-1:0] ev_set;
  reg [7:0]  status_one;
  reg [31:0] read_mux;
  wire [1:0] mode_synced;
  wire       lock_live;
  wire       gen_irq_event;
  wire       gen_rst_event;
  wire       addr_phase;
  wire       wr_now;
  wire       rd_now;

  // Decode one register offset against the latched address.
  function hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      hit = (addr[11:2] == ofs[11:2]);
    end
  endfunction

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  // Only NONSEQ or SEQ transfers are taken; hsize is accepted as a word.
  assign addr_phase = hsel & hready & htrans[1];
  assign wr_now     = pend_reg & pend_write_reg;
  assign rd_now     = pend_reg & ~pend_write_reg;

  // One wait state per access, so hrdata can come from a flip-flop.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg       <= 1'b0;
      pend_write_reg <= 1'b0;
      pend_addr_reg  <= 12'h000;
      hreadyout      <= 1'b1;
      hresp          <= 1'b0;
      hrdata         <= 32'h00000000;
    end else begin
      hresp <= 1'b0;
      if (pend_reg) begin
        pend_reg  <= 1'b0;
        hreadyout <= 1'b1;
        if (!pend_write_reg) begin
          hrdata <= read_mux;
        end
      end else if (addr_phase) begin
        pend_reg       <= 1'b1;
        pend_write_reg <= hwrite;
        pend_addr_reg  <= haddr;
        hreadyout      <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  // Mode select and the two reset enables steer the logic below.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_reg <= `RST_CONTROL;
    end else if (wr_now && hit(pend_addr_reg, `OFS_CONTROL)) begin
      control_reg <= hwdata[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // Mode crossing and mode status
  // ----------------------------------------------------------------------
  // The written select reaches the status field three edges later.
  mode_sync #(
    .WIDTH (2)
  ) u_mode_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .mode_in  (control_reg[`CTL_SEL_HI:`CTL_SEL_LO]),
    .mode_out (mode_synced)
  );

  // Off mode freezes the status; leaving off with an engaged select parks in
  // self-clocked until the oscillator is stable. A bypass request waits for
  // a stable reference, and a lost reference falls back to self-clocked.
  always @* begin
    mode_status_next = mode_synced;
    if (gen_off) begin
      mode_status_next = mode_status_reg;
    end else if (leave_wait_reg && !osc_stable_reg) begin
      mode_status_next = `MODE_SELF;
    end else if (mode_synced[1] && !ext_ref_stable_in && loc_flag_reg) begin
      mode_status_next = `MODE_SELF;
    end else if (mode_synced == `MODE_BYP_EXT && !ext_ref_stable_in) begin
      mode_status_next = mode_status_reg;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_status_reg <= `RST_MODE;
      leave_wait_reg  <= 1'b0;
      mode_request    <= `RST_MODE;
    end else begin
      mode_status_reg <= mode_status_next;
      mode_request    <= mode_status_next;
      if (gen_off) begin
        leave_wait_reg <= mode_synced[0];
      end else if (osc_stable_reg) begin
        leave_wait_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Lock indicator
  // ----------------------------------------------------------------------
  // Only the two engaged modes may show lock.
  assign lock_live = fll_locked & ~gen_off &
                     ((mode_status_reg == `MODE_FLL_INT) |
                      (mode_status_reg == `MODE_FLL_EXT));

  // ----------------------------------------------------------------------
  // Sticky loss flags and their requests
  // ----------------------------------------------------------------------
  // A loss pulse is an interrupt or a reset request as the enable bit says.
  assign gen_irq_event = (lock_lost_pulse & ~control_reg[`CTL_LOCK_LOSS_RESET_ENABLE_BIT]) |
                         (clock_lost_pulse & ~control_reg[`CTL_CLOCK_LOSS_RESET_ENABLE_BIT]);
  assign gen_rst_event = (lock_lost_pulse & control_reg[`CTL_LOCK_LOSS_RESET_ENABLE_BIT]) |
                         (clock_lost_pulse & control_reg[`CTL_CLOCK_LOSS_RESET_ENABLE_BIT]);

  // The loss flags clear only by reset; software writes cannot touch them.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lol_flag_reg  <= 1'b0;
      loc_flag_reg  <= 1'b0;
      reset_request <= 1'b0;
    end else begin
      if (lock_lost_pulse) begin
        lol_flag_reg <= 1'b1;
      end
      if (clock_lost_pulse) begin
        loc_flag_reg <= 1'b1;
      end
      if (gen_rst_event) begin
        reset_request <= 1'b1; // Held until the system reset arrives.
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt-pending flag and its clear sequence
  // ----------------------------------------------------------------------
  // A read with the flag set arms; a later write of one clears when armed.
  // A new interrupt disarms, so an older clear cannot swallow it.
  always @* begin
    irq_flag_next    = irq_flag_reg;
    clear_armed_next = clear_armed_reg;
    if (rd_now && hit(pend_addr_reg, `OFS_STATUS_ONE) && irq_flag_reg) begin
      clear_armed_next = 1'b1;
    end
    if (wr_now && hit(pend_addr_reg, `OFS_STATUS_ONE)) begin
      if (hwdata[`ST1_IRQ_BIT] && clear_armed_reg) begin
        irq_flag_next = 1'b0;
      end
      clear_armed_next = 1'b0;
    end
    if (gen_irq_event) begin
      irq_flag_next    = 1'b1;
      clear_armed_next = 1'b0;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_flag_reg    <= 1'b0;
      clear_armed_reg <= 1'b0;
    end else begin
      irq_flag_reg    <= irq_flag_next;
      clear_armed_reg <= clear_armed_next;
    end
  end

  // ----------------------------------------------------------------------
  // Oscillator stability
  // ----------------------------------------------------------------------
  // Two consecutive in-tolerance samples with a running clock set the flag;
  // a bad sample or a static clock restarts the count.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      good_count_reg     <= 2'h0;
      osc_stable_reg     <= 1'b0;
      osc_monitor_enable <= 1'b0;
    end else begin
      if (gen_off) begin
        good_count_reg <= 2'h0;
        osc_stable_reg <= 1'b0;
      end else if (!osc_clock_active) begin
        good_count_reg <= 2'h0;
        osc_stable_reg <= 1'b0;
      end else if (osc_sample_valid) begin
        if (!osc_sample_in_tol) begin
          good_count_reg <= 2'h0;
          osc_stable_reg <= 1'b0;
        end else if (good_count_reg == `OSC_STABLE_SAMPLES - 2'h1) begin
          good_count_reg <= `OSC_STABLE_SAMPLES;
          osc_stable_reg <= 1'b1;
        end else if (good_count_reg != `OSC_STABLE_SAMPLES) begin
          good_count_reg <= good_count_reg + 2'h1;
        end
      end
      osc_monitor_enable <= osc_stable_reg & ~gen_off &
                            (mode_status_reg == `MODE_SELF);
    end
  end

  // ----------------------------------------------------------------------
  // Event status, enable and interrupt output
  // ----------------------------------------------------------------------
  always @* begin
    ev_set = {`EV_WIDTH{1'b0}};
    ev_set[`EV_LOCK_LOST]   = lock_lost_pulse;
    ev_set[`EV_CLOCK_LOST]  = clock_lost_pulse;
    ev_set[`EV_OSC_STABLE]  = osc_sample_valid & osc_sample_in_tol & osc_clock_active &
                              ~gen_off & ~osc_stable_reg &
                              (good_count_reg == `OSC_STABLE_SAMPLES - 2'h1);
    ev_set[`EV_MODE_CHANGE] = (mode_status_next != mode_status_reg);
  end

  // Set wins over a clear in the same cycle, so no event is lost.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_status_reg <= `RST_EVENTS;
      ev_enable_reg <= `RST_EVENTS;
      irq           <= 1'b0;
    end else begin
      if (wr_now && hit(pend_addr_reg, `OFS_EVENT_CLEAR)) begin
        ev_status_reg <= (ev_status_reg & ~hwdata[`EV_WIDTH-1:0]) | ev_set;
      end else begin
        ev_status_reg <= ev_status_reg | ev_set;
      end
      if (wr_now && hit(pend_addr_reg, `OFS_EVENT_ENABLE)) begin
        ev_enable_reg <= hwdata[`EV_WIDTH-1:0];
      end
      irq <= |(ev_status_reg & ev_enable_reg);
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Status fields other than the pending flag have no write path, so writes to them fall away.
  always @* begin
    status_one = 8'h00;
    status_one[`ST1_MODE_HI:`ST1_MODE_LO] = mode_status_reg;
    status_one[`ST1_REF_BIT]  = crystal_selected;
    status_one[`ST1_LOL_BIT]  = lol_flag_reg;
    status_one[`ST1_LOCK_BIT] = lock_live;
    status_one[`ST1_LOC_BIT]  = loc_flag_reg;
    status_one[`ST1_ERS_BIT]  = ext_ref_stable_in;
    status_one[`ST1_IRQ_BIT]  = irq_flag_reg;
    read_mux = 32'h00000000;
    if (hit(pend_addr_reg, `OFS_STATUS_ONE)) begin
      read_mux[7:0] = status_one;
    end else if (hit(pend_addr_reg, `OFS_STATUS_TWO)) begin
      read_mux[`ST2_OSC_BIT] = osc_stable_reg;
    end else if (hit(pend_addr_reg, `OFS_CONTROL)) begin
      read_mux[3:0] = control_reg;
    end else if (hit(pend_addr_reg, `OFS_EVENT_STATUS)) begin
      read_mux[`EV_WIDTH-1:0] = ev_status_reg;
    end else if (hit(pend_addr_reg, `OFS_EVENT_ENABLE)) begin
      read_mux[`EV_WIDTH-1:0] = ev_enable_reg;
    end
  end

endmodule // clock_gen_status_logic

`default_nettype wire

// [verilog/clock_gen_status_consts.vh]
// Purpose: Shared offsets, field positions and reset values of the clock generator status block.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Definitions only.
`ifndef CLOCK_GEN_STATUS_CONSTS_VH
`define CLOCK_GEN_STATUS_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------------------------------------
`define OFS_STATUS_ONE    12'h000
`define OFS_STATUS_TWO    12'h004
`define OFS_CONTROL       12'h008
`define OFS_EVENT_STATUS  12'h00C
`define OFS_EVENT_CLEAR   12'h010
`define OFS_EVENT_ENABLE  12'h014

// ----------------------------------------------------------------------
// First status register field positions
// ----------------------------------------------------------------------
`define ST1_MODE_HI       7
`define ST1_MODE_LO       6
`define ST1_REF_BIT       5
`define ST1_LOL_BIT       4
`define ST1_LOCK_BIT      3
`define ST1_LOC_BIT       2
`define ST1_ERS_BIT       1
`define ST1_IRQ_BIT       0

// Second status register field position.
`define ST2_OSC_BIT       0

// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define CTL_SEL_HI        1
`define CTL_SEL_LO        0
`define CTL_LOCK_LOSS_RESET_ENABLE_BIT     2
`define CTL_CLOCK_LOSS_RESET_ENABLE_BIT     3

// ----------------------------------------------------------------------
// Clock mode encodings
// ----------------------------------------------------------------------
`define MODE_SELF         2'h0
`define MODE_FLL_INT      2'h1
`define MODE_BYP_EXT      2'h2
`define MODE_FLL_EXT      2'h3

// ----------------------------------------------------------------------
// Event status bits and reset values
// ----------------------------------------------------------------------
`define EV_LOCK_LOST      0
`define EV_CLOCK_LOST     1
`define EV_OSC_STABLE     2
`define EV_MODE_CHANGE    3
`define EV_WIDTH          4
`define RST_CONTROL       4'h0
`define RST_EVENTS        4'h0
`define RST_MODE          2'h0

// Consecutive in-tolerance samples needed for a stable oscillator.
`define OSC_STABLE_SAMPLES 2'h2

`endif

// [verilog/mode_sync.v]
// Purpose: Carries the requested clock mode across into the generator's timing.
// Assumes: Single clock; the two stages stand for the clock-domain crossing.
// Notes:   The first stage is read only by the second stage.
`default_nettype none

module mode_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset.
  input  wire             hclk,
  input  wire             hresetn,
  // Mode in and out.
  input  wire [WIDTH-1:0] mode_in,
  output reg  [WIDTH-1:0] mode_out
);

  reg [WIDTH-1:0] stage_reg;

  // ----------------------------------------------------------------------
  // Two-stage transfer
  // ----------------------------------------------------------------------
  // Two stages so the mode is never seen in the cycle it was written.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_reg <= {WIDTH{1'b0}};
      mode_out  <= {WIDTH{1'b0}};
    end else begin
      stage_reg <= mode_in;
      mode_out  <= stage_reg;
    end
  end

endmodule // mode_sync

`default_nettype wire

// [sim/clock_gen_status_logic_sva.sv]
// Purpose: Port-level checks of the clock generator status block.
// Assumes: One clock; hready is the slave's own hreadyout.
// Notes:   Bound to the design module at the foot of this file.
`default_nettype none

module clock_gen_status_logic_sva (
  // Clock and reset.
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus signals.
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Generator signals.
  input wire logic        gen_off,
  input wire logic        lock_lost_pulse,
  input wire logic        clock_lost_pulse,
  input wire logic        osc_clock_active,
  input wire logic [1:0]  mode_request,
  input wire logic        osc_monitor_enable,
  input wire logic        reset_request
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Marks the data phase of a read, the only time hrdata may move.
  logic rd_pend;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      rd_pend <= 1'b0;
    else
      rd_pend <= hsel && hready && htrans[1] && !hwrite;
  end

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  property p_resp_okay; hresp == 1'b0; endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("hresp not OKAY");
  property p_one_wait; hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");
  property p_wait_cause; $fell(hreadyout) |-> $past(hsel && hready && htrans[1]); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait state without request");
  property p_rdata_hold; !rd_pend |=> $stable(hrdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("hrdata moved outside a read");

  // ----------------------------------------------------------------
  // Generator outputs
  // ----------------------------------------------------------------
  property p_mon_off; gen_off |=> !osc_monitor_enable; endproperty
  a_mon_off: assert property (p_mon_off) else $error("monitor on in off state");
  property p_mon_static; !osc_clock_active |-> ##2 !osc_monitor_enable; endproperty
  a_mon_static: assert property (p_mon_static) else $error("monitor on, clock static");
  property p_mon_mode; osc_monitor_enable |-> $past(mode_request) == 2'h0; endproperty
  a_mon_mode: assert property (p_mon_mode) else $error("monitor on outside self mode");
  property p_rst_cause;
    $rose(reset_request) |-> $past(lock_lost_pulse) || $past(lock_lost_pulse, 2)
      || $past(clock_lost_pulse) || $past(clock_lost_pulse, 2);
  endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("reset request without loss");
  property p_rst_sticky; reset_request |=> reset_request; endproperty
  a_rst_sticky: assert property (p_rst_sticky) else $error("reset request dropped");
endmodule // clock_gen_status_logic_sva

bind clock_gen_status_logic clock_gen_status_logic_sva u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hready(hready), .htrans(htrans),
  .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .gen_off(gen_off), .lock_lost_pulse(lock_lost_pulse), .clock_lost_pulse(clock_lost_pulse),
  .osc_clock_active(osc_clock_active), .mode_request(mode_request),
  .osc_monitor_enable(osc_monitor_enable), .reset_request(reset_request)
);
`default_nettype wire

// [sim/clock_gen_status_logic_tb.sv]
// Purpose: Self-checking bench for the clock generator status block.
// Assumes: One AHB-Lite master; hready is the slave's hreadyout.
// Notes:   Generator inputs are driven straight from the scenarios.
`default_nettype none
`include "clock_gen_status_consts.vh"

module clock_gen_status_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [11:0] haddr;
  logic [1:0]  htrans, mode_request, prev;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  wire         hready;
  logic        gen_off, fll_locked, lock_lost_pulse, clock_lost_pulse, ext_ref_stable_in;
  logic        crystal_selected, osc_sample_valid, osc_sample_in_tol, osc_clock_active;
  logic        osc_monitor_enable, reset_request;
  int          fails = 0;
  int          checks = 0;
  logic [1:0]  modes [4] = '{2'h1, 2'h3, 2'h2, 2'h0};

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  clock_gen_status_logic u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .gen_off(gen_off), .fll_locked(fll_locked),
    .lock_lost_pulse(lock_lost_pulse), .clock_lost_pulse(clock_lost_pulse),
    .ext_ref_stable_in(ext_ref_stable_in), .crystal_selected(crystal_selected),
    .osc_sample_valid(osc_sample_valid), .osc_sample_in_tol(osc_sample_in_tol),
    .osc_clock_active(osc_clock_active), .mode_request(mode_request),
    .osc_monitor_enable(osc_monitor_enable), .reset_request(reset_request), .irq(irq)
  );

  // Free-running 200 MHz clock.
  initial hclk = 1'b0;
  always #2.5 hclk = ~hclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // One single transfer; waits on hready in both phases, as a real master must.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic do_reset;
    hresetn <= 1'b0;
    idle(5);
    hresetn <= 1'b1;
    idle(1);
  endtask

  task automatic pulse(input logic lock);
    if (lock)
      lock_lost_pulse <= 1'b1;
    else
      clock_lost_pulse <= 1'b1;
    @(posedge hclk);
    lock_lost_pulse <= 1'b0;
    clock_lost_pulse <= 1'b0;
  endtask

  task automatic samples(input int n, input logic good = 1'b1);
    repeat (n) begin
      osc_sample_valid <= 1'b1;
      osc_sample_in_tol <= good;
      @(posedge hclk);
      osc_sample_valid <= 1'b0;
      @(posedge hclk);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    bus(0, `OFS_STATUS_ONE, 0); check("status one", rd, 0);
    bus(0, `OFS_STATUS_TWO, 0); check("status two", rd, 0);
    bus(0, 12'h020, 0); check("unmapped", rd, 0);
  endtask

  task automatic t_reference;
    for (int v = 0; v < 2; v++) begin
      crystal_selected <= v[0];
      ext_ref_stable_in <= v[0];
      idle(2);
      bus(0, `OFS_STATUS_ONE, 0);
      check("ref bit", rd[5], v[0]);
      check("ext stable bit", rd[1], v[0]);
    end
  endtask

  task automatic t_osc_stable;
    osc_clock_active <= 1'b1;
    samples(1); bus(0, `OFS_STATUS_TWO, 0); check("osc one sample", rd, 0);
    samples(1, 1'b0); samples(1);
    bus(0, `OFS_STATUS_TWO, 0); check("osc after bad sample", rd, 0);
    samples(1); bus(0, `OFS_STATUS_TWO, 0); check("osc two samples", rd, 1);
  endtask

  // Reads straight after each select write must still show the old mode.
  task automatic t_modes;
    prev = 2'h0;
    foreach (modes[i]) begin
      bus(1, `OFS_CONTROL, {30'h0, modes[i]});
      bus(0, `OFS_STATUS_ONE, 0); check("mode held", rd[7:6], prev);
      idle(4);
      bus(0, `OFS_STATUS_ONE, 0); check("mode", rd[7:6], modes[i]);
      check("mode request", mode_request, modes[i]);
      check("lock bit", rd[3], modes[i][0]);
      check("monitor", osc_monitor_enable, modes[i] == 2'h0);
      prev = modes[i];
    end
  endtask

  task automatic t_off_state;
    bus(1, `OFS_CONTROL, 32'h1); idle(4);
    fll_locked <= 1'b0;
    bus(0, `OFS_STATUS_ONE, 0); check("lock follows loop", rd[3], 0);
    fll_locked <= 1'b1;
    gen_off <= 1'b1; idle(3);
    bus(0, `OFS_STATUS_ONE, 0); check("lock in off", rd[3], 0);
    bus(0, `OFS_STATUS_TWO, 0); check("osc in off", rd, 0);
    gen_off <= 1'b0; idle(4);
    bus(0, `OFS_STATUS_ONE, 0); check("mode before stable", rd[7:6], 0);
    samples(2); idle(4);
    bus(0, `OFS_STATUS_ONE, 0); check("mode after stable", rd[7:6], 1);
    bus(1, `OFS_CONTROL, 32'h0); idle(4);
  endtask

  task automatic t_flag_and_irq;
    pulse(1); idle(2);
    bus(1, `OFS_STATUS_ONE, 32'h1);
    bus(0, `OFS_STATUS_ONE, 0); check("flag kept unread", rd[0], 1);
    check("lock loss", rd[4], 1);
    bus(1, `OFS_STATUS_ONE, 32'hFE); bus(1, `OFS_STATUS_TWO, 32'h0);
    bus(0, `OFS_STATUS_ONE, 0); check("status one kept", rd[7:0], 8'h33);
    bus(0, `OFS_STATUS_TWO, 0); check("status two kept", rd, 1);
    pulse(0);
    bus(1, `OFS_STATUS_ONE, 32'h1);
    bus(0, `OFS_STATUS_ONE, 0); check("flag after new irq", rd[0], 1);
    bus(1, `OFS_STATUS_ONE, 32'h1);
    bus(0, `OFS_STATUS_ONE, 0); check("flag cleared", rd[7:0], 8'h36);
    check("no reset req", reset_request, 0);
    bus(0, `OFS_EVENT_STATUS, 0); check("events", rd[3:0], 4'hF);
    check("irq masked", irq, 0);
    bus(1, `OFS_EVENT_ENABLE, 32'h3); idle(2); check("irq on", irq, 1);
    bus(1, `OFS_EVENT_ENABLE, 32'h0); idle(2); check("irq mask", irq, 0);
    bus(1, `OFS_EVENT_ENABLE, 32'h3); bus(1, `OFS_EVENT_CLEAR, 32'h3); idle(2);
    check("irq cleared", irq, 0);
    bus(0, `OFS_EVENT_STATUS, 0); check("events cleared", rd[3:0], 4'hC);
    bus(0, `OFS_EVENT_CLEAR, 0); check("clear reads zero", rd, 0);
  endtask

  task automatic t_reset_request;
    for (int k = 0; k < 2; k++) begin
      do_reset;
      bus(1, `OFS_CONTROL, k ? 32'h8 : 32'h4);
      pulse(k == 0); idle(3);
      check("reset req", reset_request, 1);
      bus(0, `OFS_STATUS_ONE, 0); check("no irq flag", rd[0], 0);
      check("loss flag", rd[k ? 2 : 4], 1);
    end
    do_reset; check("reset req cleared", reset_request, 0);
  endtask

  // Watchdog well beyond the few hundred cycles the run needs.
  initial begin
    #50000;
    fails++;
    finish_test;
  end

  // Main sequence.
  initial begin
    hsel = 1'b0; haddr = 12'h000; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0; gen_off = 1'b0; fll_locked = 1'b1; lock_lost_pulse = 1'b0;
    clock_lost_pulse = 1'b0; ext_ref_stable_in = 1'b0; crystal_selected = 1'b0;
    osc_sample_valid = 1'b0; osc_sample_in_tol = 1'b0; osc_clock_active = 1'b0;
    do_reset;
    t_reset_values;
    t_reference;
    t_osc_stable;
    t_modes;
    t_off_state;
    t_flag_and_irq;
    t_reset_request;
    finish_test;
  end
endmodule // clock_gen_status_logic_tb
`default_nettype wire
